// ### msas_regs.vh
// Command codes, field positions, reset values and timing for the
// monitor ADC scheduler and limit alarm block.
// Included by the scheduler module only; holds definitions only.
`ifndef MSAS_REGS_VH
`define MSAS_REGS_VH

// Command codes of the 16-bit registers
`define MSAS_CMD_BACKUP_CH_EN    8'h07
`define MSAS_CMD_CHARGE_PAUSE    8'h08
`define MSAS_CMD_BACKUP_PAUSE    8'h09
`define MSAS_CMD_AUX_LOW         8'h0a
`define MSAS_CMD_AUX_HIGH        8'h0b
`define MSAS_CMD_INPUT_LOW       8'h0c
`define MSAS_CMD_INPUT_HIGH      8'h0d
`define MSAS_CMD_STACK_LOW       8'h0e
`define MSAS_CMD_STACK_HIGH      8'h0f
`define MSAS_CMD_OUTPUT_LOW      8'h10
`define MSAS_CMD_OUTPUT_HIGH     8'h11

// Field positions in the backup channel enable register
`define MSAS_BIT_BACKUP_OUTPUT   5
`define MSAS_BIT_BACKUP_CELL3    10
`define MSAS_BIT_BACKUP_CELL4    11

// Reset values
`define MSAS_RST_PAUSE           16'h0064
`define MSAS_RST_LIMIT           16'h0000
`define MSAS_RST_BACKUP_CH_EN    16'h0000

// Channel numbers of the conversion sequence
`define MSAS_CH_AUX              3'h0
`define MSAS_CH_INPUT            3'h1
`define MSAS_CH_STACK            3'h2
`define MSAS_CH_OUTPUT           3'h3
`define MSAS_CH_CELL1            3'h4
`define MSAS_CH_CELL2            3'h5
`define MSAS_CH_CELL3            3'h6
`define MSAS_CH_CELL4            3'h7

// Timing: one pause count in ns, and the clock period in ns
`define MSAS_PAUSE_LSB_NS        400000
`define MSAS_CLK_PERIOD_NS       25

`endif

// ### msas_tick.v
// Free-running prescaler giving one pulse per pause count.
// Assumes a single clock; restart_i realigns the count to zero.
`timescale 1ns/1ps
`default_nettype none

module msas_tick #(
	parameter integer TICK_CYCLES = 16000
) (
	input  wire        core_clk_i,
	input  wire        srst_i,
	input  wire        restart_i,
	output wire        tick_o
);

	reg [15:0] count;

	// Count cycles and wrap after one full pause count
	always @(posedge core_clk_i) begin
		if (srst_i || restart_i || tick_o) begin
			count <= 16'h0000;
		end else begin
			count <= count + 16'h0001;
		end
	end

	assign tick_o = (count == TICK_CYCLES[15:0] - 16'h0001);

endmodule // msas_tick

`default_nettype wire

// ### msas_limit_cmp.v
// Strict window comparator for one conversion result.
// Assumes limits and enables are stable while valid_i is high.
`timescale 1ns/1ps
`default_nettype none

module msas_limit_cmp #(
	parameter integer WIDTH = 16
) (
	input  wire [WIDTH-1:0] value_i,
	input  wire [WIDTH-1:0] low_limit_i,
	input  wire [WIDTH-1:0] high_limit_i,
	input  wire             low_en_i,
	input  wire             high_en_i,
	input  wire             valid_i,
	output wire             below_o,
	output wire             above_o
);

	// Strict compares, each gated by its enable
	assign below_o = valid_i && low_en_i && (value_i < low_limit_i);
	assign above_o = valid_i && high_en_i && (value_i > high_limit_i);

endmodule // msas_limit_cmp

`default_nettype wire

// ### msas_sched_alarm.v
// Measurement scheduler and voltage limit alarms of the monitor ADC.
// Assumes an SMBus protocol engine on the same clock that presents a
// command code with a write strobe, and an ADC that answers each start
// with one done pulse carrying a 16-bit result.
`timescale 1ns/1ps
`default_nettype none
`include "msas_regs.vh"

module msas_sched_alarm #(
	parameter integer TICK_CYCLES = `MSAS_PAUSE_LSB_NS / `MSAS_CLK_PERIOD_NS
) (
	input  wire        core_clk_i,
	input  wire        srst_i,
	// Register access by command code
	input  wire [7:0]  cmd_code_i,
	input  wire        cmd_wr_i,
	input  wire [15:0] cmd_wr_data_i,
	output reg  [15:0] cmd_rd_data_o,
	// Operating state
	input  wire        backup_mode_i,
	input  wire        own_schedule_i,
	input  wire [7:0]  charge_chan_en_i,
	input  wire [7:0]  backup_other_en_i,
	// Converter handshake
	output reg         conv_start_o,
	output reg  [2:0]  conv_chan_o,
	input  wire        conv_done_i,
	input  wire [15:0] conv_data_i,
	// Results for balancing and shunt control
	output reg         bal_update_o,
	output reg  [2:0]  bal_chan_o,
	output reg  [15:0] bal_data_o,
	// Alarm enables, flags and clears
	input  wire [7:0]  alarm_en_i,
	input  wire [7:0]  alarm_clear_i,
	output reg  [7:0]  alarm_flags_o,
	// Open-drain alert pin
	output wire        alert_n_out_o,
	output reg         alert_n_oe_n_o,
	// Round progress
	output wire        round_busy_o
);

	// One-hot sequencer states
	localparam [2:0] ST_PICK = 3'b001;
	localparam [2:0] ST_CONV = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;

	reg  [15:0] backup_ch_en;
	reg  [15:0] charge_round_pause;
	reg  [15:0] backup_round_pause;
	reg  [15:0] aux_input_low_limit;
	reg  [15:0] aux_input_high_limit;
	reg  [15:0] input_rail_low_limit;
	reg  [15:0] input_rail_high_limit;
	reg  [15:0] stack_low_limit;
	reg  [15:0] stack_high_limit;
	reg  [15:0] output_rail_low_limit;
	reg  [15:0] output_rail_high_limit;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [2:0]  chan;
	reg  [2:0]  next_chan;
	reg  [15:0] pause_left;
	reg  [15:0] next_pause_left;
	reg         tick_restart;
	reg  [7:0]  backup_en;
	reg  [7:0]  active_en;
	reg  [15:0] sel_low;
	reg  [15:0] sel_high;
	reg  [15:0] read_mux;
	reg  [7:0]  alarm_set;
	reg  [7:0]  next_flags;

	wire        backup_cell3_sample_on;
	wire        backup_cell4_sample_on;
	wire        backup_output_sample_on;
	wire        tick;
	wire        result_valid;
	wire        is_limited;
	wire        below;
	wire        above;
	wire [15:0] round_pause;

	// True when a write targets the given command code
	function wr_hit;
		input [7:0] code;
		input [7:0] target;
		input       strobe;
		begin
			wr_hit = strobe && (code == target);
		end
	endfunction

	// Alarm vector for a channel: under at 2*ch, over at 2*ch+1
	function [7:0] alarm_bits;
		input [2:0] ch;
		input       lo;
		input       hi;
		begin
			alarm_bits = 8'h00;
			if (ch[2] == 1'b0) begin
				alarm_bits[{ch[1:0], 1'b0}] = lo;
				alarm_bits[{ch[1:0], 1'b1}] = hi;
			end
		end
	endfunction

	// Backup enable fields
	assign backup_cell3_sample_on  = backup_ch_en[`MSAS_BIT_BACKUP_CELL3];
	assign backup_cell4_sample_on  = backup_ch_en[`MSAS_BIT_BACKUP_CELL4];
	assign backup_output_sample_on = backup_ch_en[`MSAS_BIT_BACKUP_OUTPUT];

	// Register writes by command code
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			backup_ch_en           <= `MSAS_RST_BACKUP_CH_EN;
			charge_round_pause     <= `MSAS_RST_PAUSE;
			backup_round_pause     <= `MSAS_RST_PAUSE;
			aux_input_low_limit    <= `MSAS_RST_LIMIT;
			aux_input_high_limit   <= `MSAS_RST_LIMIT;
			input_rail_low_limit   <= `MSAS_RST_LIMIT;
			input_rail_high_limit  <= `MSAS_RST_LIMIT;
			stack_low_limit        <= `MSAS_RST_LIMIT;
			stack_high_limit       <= `MSAS_RST_LIMIT;
			output_rail_low_limit  <= `MSAS_RST_LIMIT;
			output_rail_high_limit <= `MSAS_RST_LIMIT;
		end else begin
			if (wr_hit(cmd_code_i, `MSAS_CMD_BACKUP_CH_EN, cmd_wr_i)) begin
				// Only the enables owned here are stored
				backup_ch_en <= 16'h0000;
				backup_ch_en[`MSAS_BIT_BACKUP_CELL3] <=
					cmd_wr_data_i[`MSAS_BIT_BACKUP_CELL3];
				backup_ch_en[`MSAS_BIT_BACKUP_CELL4] <=
					cmd_wr_data_i[`MSAS_BIT_BACKUP_CELL4];
				backup_ch_en[`MSAS_BIT_BACKUP_OUTPUT] <=
					cmd_wr_data_i[`MSAS_BIT_BACKUP_OUTPUT];
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_CHARGE_PAUSE, cmd_wr_i)) begin
				charge_round_pause <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_BACKUP_PAUSE, cmd_wr_i)) begin
				backup_round_pause <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_AUX_LOW, cmd_wr_i)) begin
				aux_input_low_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_AUX_HIGH, cmd_wr_i)) begin
				aux_input_high_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_INPUT_LOW, cmd_wr_i)) begin
				input_rail_low_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_INPUT_HIGH, cmd_wr_i)) begin
				input_rail_high_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_STACK_LOW, cmd_wr_i)) begin
				stack_low_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_STACK_HIGH, cmd_wr_i)) begin
				stack_high_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_OUTPUT_LOW, cmd_wr_i)) begin
				output_rail_low_limit <= cmd_wr_data_i;
			end
			if (wr_hit(cmd_code_i, `MSAS_CMD_OUTPUT_HIGH, cmd_wr_i)) begin
				output_rail_high_limit <= cmd_wr_data_i;
			end
		end
	end

	// Read mux; unknown codes read as zero
	always @* begin
		case (cmd_code_i)
			`MSAS_CMD_BACKUP_CH_EN: read_mux = backup_ch_en;
			`MSAS_CMD_CHARGE_PAUSE: read_mux = charge_round_pause;
			`MSAS_CMD_BACKUP_PAUSE: read_mux = backup_round_pause;
			`MSAS_CMD_AUX_LOW:      read_mux = aux_input_low_limit;
			`MSAS_CMD_AUX_HIGH:     read_mux = aux_input_high_limit;
			`MSAS_CMD_INPUT_LOW:    read_mux = input_rail_low_limit;
			`MSAS_CMD_INPUT_HIGH:   read_mux = input_rail_high_limit;
			`MSAS_CMD_STACK_LOW:    read_mux = stack_low_limit;
			`MSAS_CMD_STACK_HIGH:   read_mux = stack_high_limit;
			`MSAS_CMD_OUTPUT_LOW:   read_mux = output_rail_low_limit;
			`MSAS_CMD_OUTPUT_HIGH:  read_mux = output_rail_high_limit;
			default:                read_mux = 16'h0000;
		endcase
	end

	// Registered read data, one cycle behind the code
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			cmd_rd_data_o <= 16'h0000;
		end else begin
			cmd_rd_data_o <= read_mux;
		end
	end

	// Channel enables of the present mode
	always @* begin
		backup_en = backup_other_en_i;
		backup_en[`MSAS_CH_OUTPUT] = backup_output_sample_on;
		backup_en[`MSAS_CH_CELL3]  = backup_cell3_sample_on;
		backup_en[`MSAS_CH_CELL4]  = backup_cell4_sample_on;
		active_en = backup_mode_i ? backup_en : charge_chan_en_i;
	end

	// Pause for the present mode; zero while running own schedule in charging mode
	assign round_pause = backup_mode_i ? backup_round_pause :
		(own_schedule_i ? 16'h0000 : charge_round_pause);

	// Pause count prescaler
	msas_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.restart_i  (tick_restart),
		.tick_o     (tick)
	);

	// Round sequencer: convert the enabled channels in order, then wait out the round pause
	always @* begin
		next_state      = state;
		next_chan       = chan;
		next_pause_left = pause_left;
		tick_restart    = 1'b0;
		case (state)
			ST_PICK: begin
				if (active_en[chan]) begin
					next_state = ST_CONV;
				end else if (chan == `MSAS_CH_CELL4) begin
					next_state      = ST_WAIT;
					next_pause_left = round_pause;
					tick_restart    = 1'b1;
				end else begin
					next_chan = chan + 3'h1;
				end
			end
			ST_CONV: begin
				if (conv_done_i) begin
					if (chan == `MSAS_CH_CELL4) begin
						next_state      = ST_WAIT;
						next_pause_left = round_pause;
						tick_restart    = 1'b1;
					end else begin
						next_state = ST_PICK;
						next_chan  = chan + 3'h1;
					end
				end
			end
			ST_WAIT: begin
				if (pause_left == 16'h0000 ||
				    (own_schedule_i && !backup_mode_i)) begin
					next_state = ST_PICK;
					next_chan  = `MSAS_CH_AUX;
				end else if (tick) begin
					next_pause_left = pause_left - 16'h0001;
				end
			end
			default: begin
				next_state = ST_PICK;
				next_chan  = `MSAS_CH_AUX;
			end
		endcase
	end

	// Sequencer registers and converter start
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			state        <= ST_PICK;
			chan         <= `MSAS_CH_AUX;
			pause_left   <= 16'h0000;
			conv_start_o <= 1'b0;
			conv_chan_o  <= 3'h0;
		end else begin
			state        <= next_state;
			chan         <= next_chan;
			pause_left   <= next_pause_left;
			conv_start_o <= (state == ST_PICK) && (next_state == ST_CONV);
			if ((state == ST_PICK) && (next_state == ST_CONV)) begin
				conv_chan_o <= chan;
			end
		end
	end

	assign round_busy_o = (state != ST_WAIT);
	assign result_valid = (state == ST_CONV) && conv_done_i;
	assign is_limited   = (chan[2] == 1'b0);

	// Limit pair for the channel just converted
	always @* begin
		case (chan)
			`MSAS_CH_AUX: begin
				sel_low  = aux_input_low_limit;
				sel_high = aux_input_high_limit;
			end
			`MSAS_CH_INPUT: begin
				sel_low  = input_rail_low_limit;
				sel_high = input_rail_high_limit;
			end
			`MSAS_CH_STACK: begin
				sel_low  = stack_low_limit;
				sel_high = stack_high_limit;
			end
			`MSAS_CH_OUTPUT: begin
				sel_low  = output_rail_low_limit;
				sel_high = output_rail_high_limit;
			end
			default: begin
				sel_low  = 16'h0000;
				sel_high = 16'hffff;
			end
		endcase
	end

	// Compare result against the selected limits
	msas_limit_cmp #(
		.WIDTH (16)
	) u_cmp (
		.value_i      (conv_data_i),
		.low_limit_i  (sel_low),
		.high_limit_i (sel_high),
		.low_en_i     (alarm_en_i[{chan[1:0], 1'b0}]),
		.high_en_i    (alarm_en_i[{chan[1:0], 1'b1}]),
		.valid_i      (result_valid && is_limited),
		.below_o      (below),
		.above_o      (above)
	);

	// Sticky alarm flags; a new event beats a clear
	always @* begin
		alarm_set  = alarm_bits(chan, below, above);
		next_flags = (alarm_flags_o & ~alarm_clear_i)
			| alarm_set;
	end

	// Flags and alert pin drive
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			alarm_flags_o  <= 8'h00;
			alert_n_oe_n_o <= 1'b1;
		end else begin
			alarm_flags_o  <= next_flags;
			alert_n_oe_n_o <= ~(|next_flags);
		end
	end

	// Alert pin only ever pulls low
	assign alert_n_out_o = 1'b0;

	// Charging-mode results forwarded to balancer and shunt control
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			bal_update_o <= 1'b0;
			bal_chan_o   <= 3'h0;
			bal_data_o   <= 16'h0000;
		end else begin
			bal_update_o <= result_valid && !backup_mode_i;
			if (result_valid && !backup_mode_i) begin
				bal_chan_o <= chan;
				bal_data_o <= conv_data_i;
			end
		end
	end

endmodule // msas_sched_alarm

`default_nettype wire

// ### msas_sched_alarm_sva.sv
// Checker of the monitor scheduler and limit alarm block.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module msas_sched_alarm_sva #(
	parameter integer TICK_CYCLES = 16000
) (
	input wire logic        core_clk_i,
	input wire logic        srst_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic        cmd_wr_i,
	input wire logic [15:0] cmd_wr_data_i,
	input wire logic [15:0] cmd_rd_data_o,
	input wire logic        backup_mode_i,
	input wire logic        own_schedule_i,
	input wire logic        conv_start_o,
	input wire logic [2:0]  conv_chan_o,
	input wire logic        conv_done_i,
	input wire logic [15:0] conv_data_i,
	input wire logic        bal_update_o,
	input wire logic [2:0]  bal_chan_o,
	input wire logic [15:0] bal_data_o,
	input wire logic [7:0]  alarm_en_i,
	input wire logic [7:0]  alarm_clear_i,
	input wire logic [7:0]  alarm_flags_o,
	input wire logic        alert_n_out_o,
	input wire logic        alert_n_oe_n_o,
	input wire logic        round_busy_o
);
	logic [15:0] regs [0:10];
	logic [15:0] exp_rd;
	logic [7:0]  hit;
	logic [31:0] idle, wait_min;
	logic [7:0]  fast;
	logic        pend, dirty;
	wire         done_ok = conv_done_i && pend;
	wire         bal_due = done_ok && !backup_mode_i;
	wire  [7:0]  new_hit = hit & {8{done_ok}};
	wire  [7:0]  clr_ok = alarm_clear_i & ~new_hit;
	wire  [7:0]  keep = alarm_flags_o & ~alarm_clear_i;
	wire  [4:0]  idx = cmd_code_i[4:0] - 5'h07;
	wire         mapped = cmd_code_i >= 8'h07 && cmd_code_i <= 8'h11;
	wire  [15:0] wmask = (cmd_code_i == 8'h07) ? 16'h0c20 : 16'hffff;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// Shadow registers, outstanding conversion and idle gap counters
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < 11; i++)
				regs[i] <= (i == 1 || i == 2) ? 16'h0064 : 16'h0000;
		end else if (cmd_wr_i && mapped) begin
			regs[idx] <= cmd_wr_data_i & wmask;
		end
		pend  <= !srst_i && (conv_start_o || (pend && !conv_done_i));
		idle  <= (srst_i || round_busy_o) ? 32'd0 : idle + 32'd1;
		fast  <= (srst_i || round_busy_o || !own_schedule_i || backup_mode_i) ? 8'd0 : fast + 8'd1;
		if (srst_i)
			dirty <= 1'b1;
		else if (round_busy_o)
			dirty <= cmd_wr_i;
		else
			dirty <= dirty | cmd_wr_i | own_schedule_i | $changed(backup_mode_i);
	end
	// Expected read word, limit hits and pause length
	always_comb begin
		exp_rd = 16'h0000;
		if (mapped)
			exp_rd = regs[idx];
		hit = 8'h00;
		if (conv_chan_o < 3'h4) begin
			hit[2*conv_chan_o]   = alarm_en_i[2*conv_chan_o] && conv_data_i < regs[3+2*conv_chan_o];
			hit[2*conv_chan_o+1] = alarm_en_i[2*conv_chan_o+1] && conv_data_i > regs[4+2*conv_chan_o];
		end
		wait_min = (backup_mode_i ? regs[2] : regs[1]) * TICK_CYCLES;
	end
	a_reg_readback: assert property (1 |=> cmd_rd_data_o == $past(exp_rd))
		else $error("read word differs from register contents");
	a_one_pending: assert property (pend |-> !conv_start_o)
		else $error("conversion started while one is outstanding");
	a_backup_gating: assert property (conv_start_o && backup_mode_i && $past(backup_mode_i) |->
		(conv_chan_o != 3'h3 || regs[0][5]) && (conv_chan_o != 3'h6 || regs[0][10]) &&
		(conv_chan_o != 3'h7 || regs[0][11]))
		else $error("disabled channel converted in backup mode");
	a_pause_len: assert property ($rose(round_busy_o) && !dirty |->
		idle >= wait_min && idle <= wait_min + 32'd3)
		else $error("idle gap between rounds has wrong length");
	a_own_fast: assert property (fast < 8'd4)
		else $error("pause not skipped on own schedule");
	a_low_alarm: assert property (done_ok |=> (alarm_flags_o & $past(hit) & 8'h55) == ($past(hit) & 8'h55))
		else $error("reading below low limit raised no flag");
	a_high_alarm: assert property (done_ok ##1 1'b1 |-> (alarm_flags_o & $past(hit) & 8'haa) == ($past(hit) & 8'haa))
		else $error("reading above high limit raised no flag");
	a_no_false: assert property (1 |=> (alarm_flags_o & ~$past(alarm_flags_o) & ~$past(new_hit)) == 8'h00)
		else $error("flag raised without a limit hit");
	a_flags_sticky: assert property (1 |=> (alarm_flags_o & $past(keep)) == $past(keep))
		else $error("flag dropped without a clear");
	a_flag_clear: assert property (1 |=> (alarm_flags_o & $past(clr_ok)) == 8'h00)
		else $error("flag survived its clear");
	a_alert_level: assert property (alert_n_oe_n_o == !(|alarm_flags_o) && !alert_n_out_o)
		else $error("alert pin disagrees with flags");
	a_bal_result: assert property (bal_due |=> bal_update_o && bal_data_o == $past(conv_data_i) &&
		bal_chan_o == $past(conv_chan_o))
		else $error("charging result not passed to balancer");
	a_bal_quiet: assert property (bal_update_o |-> $past(bal_due))
		else $error("balancer update without charging result");
	c_alarm_hit: cover property (done_ok && hit != 8'h00);
	c_clean_gap: cover property ($rose(round_busy_o) && !dirty);
	c_backup_start: cover property (conv_start_o && backup_mode_i);
	c_own_round: cover property (fast == 8'd2);
endmodule // msas_sched_alarm_sva
bind msas_sched_alarm msas_sched_alarm_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
	.core_clk_i(core_clk_i), .srst_i(srst_i), .cmd_code_i(cmd_code_i), .cmd_wr_i(cmd_wr_i),
	.cmd_wr_data_i(cmd_wr_data_i), .cmd_rd_data_o(cmd_rd_data_o), .backup_mode_i(backup_mode_i),
	.own_schedule_i(own_schedule_i), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
	.conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .bal_update_o(bal_update_o),
	.bal_chan_o(bal_chan_o), .bal_data_o(bal_data_o), .alarm_en_i(alarm_en_i),
	.alarm_clear_i(alarm_clear_i), .alarm_flags_o(alarm_flags_o), .alert_n_out_o(alert_n_out_o),
	.alert_n_oe_n_o(alert_n_oe_n_o), .round_busy_o(round_busy_o));
`default_nettype wire

// ### msas_adc_model.sv
// Converter model answering each start with one done pulse.
// Assumes the bench supplies one 16-bit reading per channel.
`timescale 1ns/1ps
`default_nettype none
module msas_adc_model (
	input  wire logic         clk_i,
	input  wire logic         start_i,
	input  wire logic [2:0]   chan_i,
	input  wire logic [127:0] vals_i,
	input  wire logic         slow_i,
	output var  logic         done_o,
	output var  logic [15:0]  data_o
);
	int         lat = 0;
	logic       busy = 1'b0;
	logic [2:0] ch = 3'h0;
	initial begin
		done_o = 1'b0;
		data_o = 16'h0000;
	end
	// Result after a short or long latency; data scrambled when idle
	always @(negedge clk_i) begin
		if (busy && lat == 0) begin
			done_o <= 1'b1;
			data_o <= vals_i[{ch, 4'h0} +: 16];
			busy = 1'b0;
		end else begin
			done_o <= 1'b0;
			data_o <= ~data_o;
			lat = lat - 1;
		end
		if (start_i === 1'b1) begin
			busy = 1'b1;
			ch   = chan_i;
			lat  = slow_i ? 12 : $urandom_range(2, 0);
		end
	end
endmodule // msas_adc_model
`default_nettype wire

// ### msas_sched_alarm_test.sv
// Self-checking bench of the monitor scheduler and limit alarms.
// Inputs change at the falling edge; a converter model answers starts.
`timescale 1ns/1ps
`default_nettype none
module msas_sched_alarm_test;
	localparam int TICKS = 4;
	logic         core_clk_i = 1'b0;
	logic         srst_i = 1'b1;
	logic         cmd_wr_i = 1'b0;
	logic         backup_mode_i = 1'b0;
	logic         own_schedule_i = 1'b0;
	logic         slow = 1'b0;
	logic [7:0]   cmd_code_i = 8'h00;
	logic [15:0]  cmd_wr_data_i = 16'h0000;
	logic [7:0]   charge_chan_en_i = 8'h0f;
	logic [7:0]   backup_other_en_i = 8'h00;
	logic [7:0]   alarm_en_i = 8'h00;
	logic [7:0]   alarm_clear_i = 8'h00;
	logic         conv_start_o, conv_done_i, bal_update_o, alert_n_out_o, alert_n_oe_n_o, round_busy_o;
	logic [2:0]   conv_chan_o, bal_chan_o;
	logic [15:0]  cmd_rd_data_o, conv_data_i, bal_data_o, q;
	logic [7:0]   alarm_flags_o, ef;
	logic [127:0] vals = '0;
	logic [15:0]  mem [0:31];
	logic [15:0]  lo [0:3];
	logic [15:0]  hi [0:3];
	int           seen [0:7];
	int           mismatches = 0;
	int           cmp_count = 0;
	int           gap, c;
	msas_sched_alarm #(.TICK_CYCLES(TICKS)) u_dut (
		.core_clk_i(core_clk_i), .srst_i(srst_i), .cmd_code_i(cmd_code_i), .cmd_wr_i(cmd_wr_i),
		.cmd_wr_data_i(cmd_wr_data_i), .cmd_rd_data_o(cmd_rd_data_o), .backup_mode_i(backup_mode_i),
		.own_schedule_i(own_schedule_i), .charge_chan_en_i(charge_chan_en_i),
		.backup_other_en_i(backup_other_en_i), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
		.conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .bal_update_o(bal_update_o),
		.bal_chan_o(bal_chan_o), .bal_data_o(bal_data_o), .alarm_en_i(alarm_en_i),
		.alarm_clear_i(alarm_clear_i), .alarm_flags_o(alarm_flags_o), .alert_n_out_o(alert_n_out_o),
		.alert_n_oe_n_o(alert_n_oe_n_o), .round_busy_o(round_busy_o));
	msas_adc_model u_adc (.clk_i(core_clk_i), .start_i(conv_start_o), .chan_i(conv_chan_o),
		.vals_i(vals), .slow_i(slow), .done_o(conv_done_i), .data_o(conv_data_i));
	// Clock and per-channel start counting
	always #12.5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) if (conv_start_o === 1'b1) seen[conv_chan_o]++;
	// Register word after a write, unmapped codes read zero
	function automatic logic [15:0] fmask(input logic [7:0] a, input logic [15:0] d);
		if (a == 8'h07)
			return d & 16'h0c20;
		return (a >= 8'h08 && a <= 8'h11) ? d : 16'h0000;
	endfunction
	// Flags expected from readings, limits and enables
	function automatic logic [7:0] fexp(input logic [127:0] v, input logic [7:0] en);
		logic [7:0] f;
		f = 8'h00;
		for (int i = 0; i < 4; i++) begin
			f[2*i]   = en[2*i] && v[16*i +: 16] < lo[i];
			f[2*i+1] = en[2*i+1] && v[16*i +: 16] > hi[i];
		end
		return f;
	endfunction
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk_i);
		cmd_code_i = a;
		cmd_wr_data_i = d;
		cmd_wr_i = 1'b1;
		@(negedge core_clk_i);
		cmd_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk_i);
		cmd_code_i = a;
		@(negedge core_clk_i);
		q = cmd_rd_data_o;
	endtask
	task automatic clear();
		@(negedge core_clk_i);
		alarm_clear_i = 8'hff;
		@(negedge core_clk_i);
		alarm_clear_i = 8'h00;
	endtask
	// Waits for round ends; gap keeps the last idle length
	task automatic rounds(input int n);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			while (round_busy_o !== 1'b1 && k < 9000) begin
				@(negedge core_clk_i);
				k++;
			end
			gap = k;
			while (round_busy_o !== 1'b0 && k < 9000) begin
				@(negedge core_clk_i);
				k++;
			end
			if (k >= 9000)
				check(16'h0000, 16'h0001);
		end
	endtask
	// Watchdog against a hung sequence
	initial begin
		#1000000;
		mismatches++;
		final_report();
	end
	initial begin
		c = $urandom(12);
		for (int a = 0; a < 32; a++)
			mem[a] = fmask(a[7:0], (a == 8 || a == 9) ? 16'h0064 : 16'h0000);
		repeat (20) @(negedge core_clk_i);
		srst_i = 1'b0;
		// Reset values, then random writes with readback
		for (int a = 6; a < 20; a++) begin
			rd(a[7:0]);
			check(q, mem[a]);
		end
		for (int i = 0; i < 40; i++) begin
			c = $urandom_range(19, 6);
			q = (c == 8 || c == 9) ? 16'($urandom_range(3, 1)) : 16'($urandom);
			wr(c[7:0], q);
			mem[c] = fmask(c[7:0], q);
			rd(c[7:0]);
			check(q, mem[c]);
		end
		// Limit alarms with readings on and beside both limits
		wr(8'h08, 16'h0002);
		for (int t = 0; t < 16; t++) begin
			slow = t[0];
			charge_chan_en_i = {4'($urandom), 4'hf};
			for (int i = 0; i < 4; i++) begin
				lo[i] = 16'($urandom_range(30000, 2));
				hi[i] = lo[i] + 16'($urandom_range(30000, 1));
				wr(8'h0a + 8'(2 * i), lo[i]);
				wr(8'h0b + 8'(2 * i), hi[i]);
				case ($urandom_range(4, 0))
					0: vals[16*i +: 16] = lo[i] - 16'h0001;
					1: vals[16*i +: 16] = lo[i];
					2: vals[16*i +: 16] = hi[i];
					3: vals[16*i +: 16] = hi[i] + 16'h0001;
					default: vals[16*i +: 16] = 16'($urandom);
				endcase
			end
			alarm_en_i = 8'($urandom);
			clear();
			rounds(2);
			ef = fexp(vals, alarm_en_i);
			check(alarm_flags_o, ef);
			check(alert_n_oe_n_o, !(|ef));
			for (int i = 0; i < 4; i++)
				vals[16*i +: 16] = lo[i] + (hi[i] - lo[i]) / 2;
			rounds(2);
			check(alarm_flags_o, ef);
			clear();
			check({alert_n_oe_n_o, alarm_flags_o}, 16'h0100);
		end
		check(gap >= 2 * TICKS && gap <= 2 * TICKS + 3, 1'b1);
		// Backup enables of output rail and cells 3 and 4
		wr(8'h09, 16'h0001);
		for (int b = 0; b < 8; b++) begin
			backup_mode_i = 1'b0;
			wr(8'h07, {4'h0, b[1], b[0], 4'h0, b[2], 5'h00});
			backup_other_en_i = 8'($urandom);
			@(negedge core_clk_i);
			backup_mode_i = 1'b1;
			rounds(1);
			seen = '{default: 0};
			rounds(2);
			check(seen[3] != 0, b[2]);
			check(seen[6] != 0, b[0]);
			check(seen[7] != 0, b[1]);
		end
		check(gap >= TICKS && gap <= TICKS + 3, 1'b1);
		// Own schedule skips a long charging pause
		backup_mode_i = 1'b0;
		wr(8'h08, 16'h0040);
		own_schedule_i = 1'b1;
		rounds(3);
		check(gap <= 3, 1'b1);
		final_report();
	end
endmodule // msas_sched_alarm_test
`default_nettype wire
